//--- include/pdss_pkg.sv
`default_nettype none
package pdss_pkg;
    // Clock
    localparam int unsigned CLK_HZ = 40_000_000;
    // Timing figures in their own units
    localparam int unsigned REF_UPD_US      = 20;
    localparam int unsigned DETACH_US       = 200;
    localparam int unsigned GAP_US          = 20;
    localparam int unsigned CHECK_PERIOD_US = 1000;
    localparam int unsigned RESTART_MS      = 1000;
    localparam int unsigned UNATT_OUTPUT_DISCHARGE_PIN_MS  = 100;
    localparam int unsigned RAMP_STEP_US    = 20;
    // Derived cycle counts (all round down through integer division)
    localparam int unsigned REF_UPD_CYC   = (CLK_HZ / 1_000_000) * REF_UPD_US;
    localparam int unsigned DETACH_CYC    = (CLK_HZ / 1_000_000) * DETACH_US;
    localparam int unsigned GAP_CYC       = (CLK_HZ / 1_000_000) * GAP_US;
    localparam int unsigned PERIOD_CYC    = (CLK_HZ / 1_000_000) * CHECK_PERIOD_US;
    localparam int unsigned RESTART_CYC   = (CLK_HZ / 1000) * RESTART_MS;
    localparam int unsigned UNATT_CYC     = (CLK_HZ / 1000) * UNATT_OUTPUT_DISCHARGE_PIN_MS;
    localparam int unsigned RAMP_STEP_CYC = (CLK_HZ / 1_000_000) * RAMP_STEP_US;
    // Default regulation targets, mV and mA
    localparam logic [15:0] VOUT_DEFAULT_MV = 16'h1388; // 5000 mV
    localparam logic [15:0] ILIM_DEFAULT_MA = 16'h0BB8; // 3000 mA
    // Thresholds in mV
    localparam logic [15:0] SAFE0_MV       = 16'h0320; // 800 mV
    localparam logic [15:0] SAFE0_DONE_MV  = 16'h02BC; // 700 mV
    localparam logic [15:0] UNDERVOLTAGE_LOCKOUT_MV        = 16'h0AF0; // 2800 mV
    // Percentages
    localparam logic [7:0] OVP_PCT_LO   = 8'h78; // 120
    localparam logic [7:0] OVP_PCT_HI   = 8'h7D; // 125
    localparam logic [7:0] UVP_PCT      = 8'h3C; // 60
    localparam logic [7:0] SINK_PERMILLE_X = 8'h69; // 105 percent
    localparam logic [7:0] PCT_DIV      = 8'h64; // 100
    // Sequencer states, Gray along the usual path
    typedef enum logic [2:0] {
        PDSS_NOSUP   = 3'b000,
        PDSS_SETTLE  = 3'b001,
        PDSS_UNATT   = 3'b011,
        PDSS_ATT     = 3'b010,
        PDSS_FAULT   = 3'b110,
        PDSS_HRDIS   = 3'b111
    } pdss_state_e;
endpackage : pdss_pkg
`default_nettype wire

//--- hw/pdss_seq.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Reset loads 5 V, 3 A defaults
// - Optocoupler drive zero at start-up
// - Gate low below lockout or open supply
// - Short into lockout: open, restart after timer
// - Above lockout: initialise, regulate 5 V 3 A
// - 20 mA sink above 1.05 default voltage
// - Stable output: close switch, low power wait
// - Attach only when exactly one CC low
// - Attach enables all, accepts new voltages
// - Overvoltage trip 120 or 125 percent
// - Undervoltage trip tracks 60 percent
// - Lockout unattached or attached goes to fault, restarts after timer
// - Protections open switch, reclose after recovery
// - Reference updated within 20 us
// - Downward parabolic ramp, upward direct
// - Ramp long enough to avoid undershoot
// - Comparator flags output below 0.8 V
// - Hard-reset: 20 us gap each millisecond while supply below 5 V
// - Repeat checks until below 0.7 V
// - 1 mA sink when both switches off
// - Unattached discharge limited to 100 ms
// - Safe restart after 1 s reinitialises
// - Detach returns target to 5 V
module pdss_seq #(
    parameter int unsigned RESTART_CYCLES = pdss_pkg::RESTART_CYC,
    parameter int unsigned UNATT_CYCLES   = pdss_pkg::UNATT_CYC,
    parameter int unsigned RAMP_STEPS     = 8,
    parameter bit          OVP_HIGH_SEL   = 1'b0
) (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    // Supply and output measurement, mV
    input  wire logic [15:0] supply_mv_i,
    input  wire logic [15:0] vbus_mv_i,
    input  wire logic        supply_open_i,
    input  wire logic        vout_stable_i,
    // CC comparators: high when line is below sink termination threshold
    input  wire logic        cc1_below_thr_i,
    input  wire logic        cc2_below_thr_i,
    // Protocol side
    input  wire logic        new_req_i,
    input  wire logic [15:0] new_vout_mv_i,
    input  wire logic        hard_reset_i,
    input  wire logic        fault_i,
    // Outputs
    output logic             load_switch_gate_drive_o,
    output logic             output_discharge_pin_o,
    output logic             discharge_sink_1ma_o,
    output logic             supply_sink_20ma_o,
    output logic             optocoupler_drive_en_o,
    output logic             low_power_o,
    output logic             attached_o,
    output logic [15:0]      vref_mv_o,
    output logic [15:0]      ilim_ma_o,
    output logic [15:0]      ovp_level_mv_o,
    output logic [15:0]      uvp_level_mv_o,
    output logic             below_safe0_o,
    output logic             hr_done_o
);
    initial begin
        if (RAMP_STEPS < 2 || RAMP_STEPS > 63 || RESTART_CYCLES < 2 || UNATT_CYCLES < 2)
            $error("pdss_seq: unsupported parameters");
    end

    // Pin synchronisers: three flops, change accepted when second and third agree
    logic [2:0] s_cc1_ff, s_cc2_ff, s_open_ff, s_stab_ff;
    logic cc1_q_ff, cc2_q_ff, open_q_ff, stab_q_ff;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_cc1_ff  <= 3'h0;
            s_cc2_ff  <= 3'h0;
            s_open_ff <= 3'h7;
            s_stab_ff <= 3'h0;
        end else begin
            s_cc1_ff  <= {s_cc1_ff[1:0], cc1_below_thr_i};
            s_cc2_ff  <= {s_cc2_ff[1:0], cc2_below_thr_i};
            s_open_ff <= {s_open_ff[1:0], supply_open_i};
            s_stab_ff <= {s_stab_ff[1:0], vout_stable_i};
        end
    end
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cc1_q_ff  <= 1'b0;
            cc2_q_ff  <= 1'b0;
            open_q_ff <= 1'b1;
            stab_q_ff <= 1'b0;
        end else begin
            if (s_cc1_ff[1] == s_cc1_ff[2]) cc1_q_ff <= s_cc1_ff[2];
            if (s_cc2_ff[1] == s_cc2_ff[2]) cc2_q_ff <= s_cc2_ff[2];
            if (s_open_ff[1] == s_open_ff[2]) open_q_ff <= s_open_ff[2];
            if (s_stab_ff[1] == s_stab_ff[2]) stab_q_ff <= s_stab_ff[2];
        end
    end

    // Level decode
    function automatic logic [15:0] pct_of(input logic [15:0] v, input logic [7:0] p);
        logic [23:0] prod;
        prod = v * p;
        return 16'((prod / pdss_pkg::PCT_DIV) & 24'h00FFFF);
    endfunction

    wire logic        undervoltage_lockout_w      = (supply_mv_i < pdss_pkg::UNDERVOLTAGE_LOCKOUT_MV) | open_q_ff;
    wire logic [15:0] sink_lvl_w  = pct_of(pdss_pkg::VOUT_DEFAULT_MV, pdss_pkg::SINK_PERMILLE_X);
    wire logic        attach_w    = cc1_q_ff ^ cc2_q_ff;
    wire logic [7:0]  ovp_pct_w   = OVP_HIGH_SEL ? pdss_pkg::OVP_PCT_HI : pdss_pkg::OVP_PCT_LO;
    wire logic        ovp_trip_w  = supply_mv_i > ovp_level_mv_o;
    wire logic        supply_ok_w = (supply_mv_i <= sink_lvl_w);
    wire logic        below0_w    = vbus_mv_i < pdss_pkg::SAFE0_MV;
    wire logic        done0_w     = vbus_mv_i < pdss_pkg::SAFE0_DONE_MV;

    // Sequencer
    pdss_pkg::pdss_state_e state_ff, nxt_state;
    logic [31:0] tmr_ff, nxt_tmr;
    logic [31:0] per_ff;
    logic        gap_ff;
    logic [15:0] target_ff, nxt_target;
    logic        req_pend_ff;
    logic [15:0] req_mv_ff;
    logic [5:0]  ramp_idx_ff;
    logic [15:0] ramp_from_ff;
    logic [31:0] ramp_tmr_ff;
    logic        ramping_ff;
    logic        prot_w;
    logic        lock_fault_w;

    assign prot_w = ovp_trip_w | fault_i;
    // Lockout while waiting out a restart must not skip the timer
    assign lock_fault_w = state_ff == pdss_pkg::PDSS_ATT || state_ff == pdss_pkg::PDSS_UNATT
                        || state_ff == pdss_pkg::PDSS_FAULT;

    always_comb begin
        nxt_state  = state_ff;
        nxt_tmr    = tmr_ff + 32'h1;
        nxt_target = target_ff;
        case (state_ff)
            pdss_pkg::PDSS_NOSUP: begin
                nxt_tmr = 32'h0;
                nxt_target = pdss_pkg::VOUT_DEFAULT_MV;
                if (!undervoltage_lockout_w) nxt_state = pdss_pkg::PDSS_SETTLE;
            end
            pdss_pkg::PDSS_SETTLE: begin
                if (stab_q_ff && supply_ok_w) begin
                    nxt_state = pdss_pkg::PDSS_UNATT;
                    nxt_tmr   = 32'h0;
                end
            end
            pdss_pkg::PDSS_UNATT: begin
                nxt_target = pdss_pkg::VOUT_DEFAULT_MV;
                if (tmr_ff >= UNATT_CYCLES) nxt_tmr = tmr_ff;
                if (attach_w) nxt_state = pdss_pkg::PDSS_ATT;
            end
            pdss_pkg::PDSS_ATT: begin
                if (!attach_w) begin
                    nxt_target = pdss_pkg::VOUT_DEFAULT_MV;
                    nxt_state  = pdss_pkg::PDSS_UNATT;
                    nxt_tmr    = 32'h0;
                end else if (hard_reset_i) begin
                    nxt_target = pdss_pkg::VOUT_DEFAULT_MV;
                    nxt_state  = pdss_pkg::PDSS_HRDIS;
                end else if (req_pend_ff) begin
                    nxt_target = req_mv_ff;
                end
            end
            pdss_pkg::PDSS_FAULT: begin
                nxt_target = pdss_pkg::VOUT_DEFAULT_MV;
                if (tmr_ff >= RESTART_CYCLES - 1 && !prot_w && supply_ok_w)
                    nxt_state = pdss_pkg::PDSS_NOSUP;
                else if (tmr_ff >= RESTART_CYCLES - 1)
                    nxt_tmr = tmr_ff;
            end
            pdss_pkg::PDSS_HRDIS: begin
                if (gap_ff && per_ff == 32'(pdss_pkg::GAP_CYC - 1) && done0_w) begin
                    nxt_state = pdss_pkg::PDSS_UNATT;
                    nxt_tmr   = 32'h0;
                end
            end
            default: nxt_state = pdss_pkg::PDSS_NOSUP;
        endcase
        if (undervoltage_lockout_w && state_ff != pdss_pkg::PDSS_NOSUP) begin
            // Short pulling supply low while closed also restarts via timer
            nxt_state = lock_fault_w ? pdss_pkg::PDSS_FAULT
                                     : pdss_pkg::PDSS_NOSUP;
            nxt_tmr   = 32'h0;
        end else if (prot_w && state_ff != pdss_pkg::PDSS_NOSUP
                     && state_ff != pdss_pkg::PDSS_FAULT) begin
            nxt_state = pdss_pkg::PDSS_FAULT;
            nxt_tmr   = 32'h0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff  <= pdss_pkg::PDSS_NOSUP;
            tmr_ff    <= 32'h0;
            target_ff <= pdss_pkg::VOUT_DEFAULT_MV;
        end else begin
            state_ff  <= nxt_state;
            tmr_ff    <= nxt_tmr;
            target_ff <= nxt_target;
        end
    end

    // Pending request capture
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_pend_ff <= 1'b0;
            req_mv_ff   <= pdss_pkg::VOUT_DEFAULT_MV;
        end else if (new_req_i && state_ff == pdss_pkg::PDSS_ATT) begin
            req_pend_ff <= 1'b1;
            req_mv_ff   <= new_vout_mv_i;
        end else begin
            req_pend_ff <= 1'b0;
        end
    end

    // Hard-reset gap timing: 20 us open every 1 ms, only while supply is below 5 V
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            per_ff <= 32'h0;
            gap_ff <= 1'b0;
        end else if (state_ff != pdss_pkg::PDSS_HRDIS
                     || supply_mv_i >= pdss_pkg::VOUT_DEFAULT_MV) begin
            per_ff <= 32'h0;
            gap_ff <= 1'b0;
        end else if (!gap_ff && per_ff >= 32'(pdss_pkg::PERIOD_CYC - pdss_pkg::GAP_CYC - 1)) begin
            per_ff <= 32'h0;
            gap_ff <= 1'b1;
        end else if (gap_ff && per_ff >= 32'(pdss_pkg::GAP_CYC - 1)) begin
            per_ff <= 32'h0;
            gap_ff <= 1'b0;
        end else begin
            per_ff <= per_ff + 32'h1;
        end
    end

    // Reference: immediate up, parabolic steps down
    wire logic [15:0] drop_w  = ramp_from_ff - target_ff;
    wire logic [11:0] rem_w   = 12'(RAMP_STEPS) - 12'(ramp_idx_ff);
    wire logic [23:0] rem2_w  = 24'(rem_w) * 24'(rem_w);
    wire logic [23:0] n2_w    = 24'(RAMP_STEPS) * 24'(RAMP_STEPS);
    wire logic [39:0] scl_w   = 40'(drop_w) * 40'(rem2_w);
    wire logic [15:0] para_w  = target_ff + 16'(scl_w / 40'(n2_w));
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vref_mv_o    <= pdss_pkg::VOUT_DEFAULT_MV;
            ramping_ff   <= 1'b0;
            ramp_idx_ff  <= 6'h0;
            ramp_from_ff <= pdss_pkg::VOUT_DEFAULT_MV;
            ramp_tmr_ff  <= 32'h0;
        end else if (target_ff >= vref_mv_o && !ramping_ff) begin
            vref_mv_o <= target_ff;
        end else if (!ramping_ff) begin
            ramping_ff   <= 1'b1;
            ramp_from_ff <= vref_mv_o;
            ramp_idx_ff  <= 6'h1;
            ramp_tmr_ff  <= 32'h0;
        end else if (target_ff > ramp_from_ff) begin
            ramping_ff <= 1'b0;
            vref_mv_o  <= target_ff;
        end else if (ramp_tmr_ff >= 32'(pdss_pkg::RAMP_STEP_CYC - 1)) begin
            ramp_tmr_ff <= 32'h0;
            vref_mv_o   <= para_w;
            if (ramp_idx_ff >= 6'(RAMP_STEPS)) ramping_ff <= 1'b0;
            else ramp_idx_ff <= ramp_idx_ff + 6'h1;
        end else begin
            ramp_tmr_ff <= ramp_tmr_ff + 32'h1;
        end
    end

    // Output registers
    // Unattached: discharge window first, then the switch closes
    wire logic sw_on_w   = (state_ff == pdss_pkg::PDSS_ATT
                         || (state_ff == pdss_pkg::PDSS_UNATT && tmr_ff >= UNATT_CYCLES))
                         && !undervoltage_lockout_w && !prot_w;
    wire logic dis_on_w  = (state_ff == pdss_pkg::PDSS_HRDIS && !gap_ff)
                         | (state_ff == pdss_pkg::PDSS_UNATT && tmr_ff < UNATT_CYCLES && !sw_on_w);
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            load_switch_gate_drive_o <= 1'b0;
            output_discharge_pin_o   <= 1'b0;
            discharge_sink_1ma_o     <= 1'b0;
            supply_sink_20ma_o       <= 1'b0;
            optocoupler_drive_en_o   <= 1'b0;
            low_power_o              <= 1'b0;
            attached_o               <= 1'b0;
            ilim_ma_o                <= pdss_pkg::ILIM_DEFAULT_MA;
            ovp_level_mv_o           <= 16'hFFFF;
            uvp_level_mv_o           <= 16'h0000;
            below_safe0_o            <= 1'b0;
            hr_done_o                <= 1'b0;
        end else begin
            load_switch_gate_drive_o <= sw_on_w;
            output_discharge_pin_o   <= dis_on_w;
            discharge_sink_1ma_o     <= !sw_on_w && !dis_on_w;
            supply_sink_20ma_o       <= !undervoltage_lockout_w && (supply_mv_i > sink_lvl_w);
            optocoupler_drive_en_o   <= state_ff != pdss_pkg::PDSS_NOSUP && !undervoltage_lockout_w;
            low_power_o              <= state_ff == pdss_pkg::PDSS_UNATT;
            attached_o               <= state_ff == pdss_pkg::PDSS_ATT;
            ilim_ma_o                <= pdss_pkg::ILIM_DEFAULT_MA;
            ovp_level_mv_o           <= pct_of(vref_mv_o, ovp_pct_w);
            uvp_level_mv_o           <= pct_of(vref_mv_o, pdss_pkg::UVP_PCT);
            below_safe0_o            <= below0_w;
            hr_done_o                <= state_ff == pdss_pkg::PDSS_HRDIS
                                        && nxt_state == pdss_pkg::PDSS_UNATT;
        end
    end
endmodule : pdss_seq
`default_nettype wire

//--- testbench/pdss_seq_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pdss_seq_checker #(
    parameter int unsigned RESTART_CYCLES = 200,
    parameter int unsigned UNATT_CYCLES   = 100,
    parameter int unsigned RAMP_STEPS     = 8,
    parameter bit          OVP_HIGH_SEL   = 1'b0
) (
    // Watched ports
    input wire logic        ref_clk_i,
    input wire logic        rst_n_i,
    input wire logic [15:0] supply_mv_i,
    input wire logic [15:0] vbus_mv_i,
    input wire logic        cc1_below_thr_i,
    input wire logic        cc2_below_thr_i,
    input wire logic        new_req_i,
    input wire logic [15:0] new_vout_mv_i,
    input wire logic        hard_reset_i,
    input wire logic        fault_i,
    input wire logic        load_switch_gate_drive_o,
    input wire logic        output_discharge_pin_o,
    input wire logic        discharge_sink_1ma_o,
    input wire logic        supply_sink_20ma_o,
    input wire logic        attached_o,
    input wire logic [15:0] vref_mv_o,
    input wire logic [15:0] ovp_level_mv_o,
    input wire logic        below_safe0_o
);
    localparam logic [15:0] SINK_MV = 16'h1482; // 5250 mV
    logic [2:0]  up_ff;
    logic [15:0] req_v_ff;
    wire         up   = (up_ff == 3'h7);
    wire         gate = load_switch_gate_drive_o;
    wire         low  = (supply_mv_i < pdss_pkg::UNDERVOLTAGE_LOCKOUT_MV);
    wire         off  = !gate && !output_discharge_pin_o;
    wire [31:0]  pct  = OVP_HIGH_SEL ? 32'(pdss_pkg::OVP_PCT_HI) : 32'(pdss_pkg::OVP_PCT_LO);
    wire [15:0]  ov_exp = 16'(32'(vref_mv_o) * pct / 32'(pdss_pkg::PCT_DIV));
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            up_ff <= 3'h0;
        end else if (!up) begin
            up_ff <= up_ff + 3'h1;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (new_req_i) begin
            req_v_ff <= new_vout_mv_i;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_up_req;
        up && attached_o && new_req_i && (new_vout_mv_i > vref_mv_o);
    endsequence
    sequence s_hr_req;
        up && attached_o && hard_reset_i;
    endsequence
    chk_gate_lockout: assert property (low [*3] |-> !gate)
        else $error("gate closed in lockout");
    chk_sink_on: assert property ((up && !low && supply_mv_i > SINK_MV) [*3] |-> supply_sink_20ma_o)
        else $error("supply sink missing");
    chk_idle_sink: assert property ((up && off) [*3] |-> discharge_sink_1ma_o)
        else $error("idle sink missing");
    chk_attach_exact: assert property ((cc1_below_thr_i == cc2_below_thr_i) [*8] |-> !$rose(attached_o))
        else $error("attach without single line");
    chk_vref_up: assert property (s_up_req |-> ##[1:4] (vref_mv_o == req_v_ff))
        else $error("reference not raised");
    chk_ov_track: assert property ((up && $stable(vref_mv_o)) [*4] |-> ovp_level_mv_o == ov_exp)
        else $error("trip level off");
    chk_fault_open: assert property (up && fault_i |-> ##[1:2] !gate)
        else $error("switch not opened on fault");
    chk_hr_open: assert property (s_hr_req |-> ##[1:3] (!gate && output_discharge_pin_o))
        else $error("hard reset not discharging");
    chk_safe0_cmp: assert property (up && $stable(vbus_mv_i) |-> below_safe0_o == (vbus_mv_i < pdss_pkg::SAFE0_MV))
        else $error("safe zero flag wrong");
endmodule : pdss_seq_checker
bind pdss_seq pdss_seq_checker #(.RESTART_CYCLES(RESTART_CYCLES), .UNATT_CYCLES(UNATT_CYCLES),
    .RAMP_STEPS(RAMP_STEPS), .OVP_HIGH_SEL(OVP_HIGH_SEL)) u_chk (.ref_clk_i, .rst_n_i,
    .supply_mv_i, .vbus_mv_i, .cc1_below_thr_i, .cc2_below_thr_i, .new_req_i, .new_vout_mv_i,
    .hard_reset_i, .fault_i, .load_switch_gate_drive_o, .output_discharge_pin_o,
    .discharge_sink_1ma_o, .supply_sink_20ma_o, .attached_o, .vref_mv_o, .ovp_level_mv_o,
    .below_safe0_o);
`default_nettype wire

//--- testbench/pdss_sink_model.sv
`timescale 1ns/1ps
`default_nettype none
module pdss_sink_model (
    // Clock and plug control
    input  wire logic        ref_clk_i,
    input  wire logic        plug_i,
    input  wire logic        flip_i,
    input  wire logic        both_i,
    // Source side
    input  wire logic        gate_i,
    input  wire logic        dis_on_i,
    input  wire logic [15:0] supply_mv_i,
    // Far side view
    output logic             cc1_below_thr_o,
    output logic             cc2_below_thr_o,
    output var logic [15:0]  vbus_mv_o
);
    // One termination on the plugged side, both for a faulty cable
    assign cc1_below_thr_o = plug_i && (both_i || !flip_i);
    assign cc2_below_thr_o = plug_i && (both_i || flip_i);
    initial vbus_mv_o = 16'h0000;
    // Output follows the closed switch, falls while discharged
    always @(posedge ref_clk_i) begin
        if (gate_i) begin
            vbus_mv_o <= supply_mv_i;
        end else if (dis_on_i && vbus_mv_o != 16'h0000) begin
            vbus_mv_o <= vbus_mv_o - 16'h0001;
        end
    end
endmodule : pdss_sink_model
`default_nettype wire

//--- testbench/test_pdss_seq.sv
`timescale 1ns/1ps
`default_nettype none
module test_pdss_seq;
    localparam int unsigned RST_C = 200;
    localparam int unsigned UNATT_C = 100;
    localparam int unsigned CABLE_COMP_MVA = 100;
    logic        ref_clk_i = 1'b0, rst_n_i = 1'b0, stable = 1'b0, plug = 1'b0, flip = 1'b0;
    logic        both = 1'b0, req = 1'b0, hr = 1'b0, fault = 1'b0, open_p = 1'b0, dn;
    logic [15:0] supply = 16'h0000, vnew = 16'h0000, v, cur, last, d0, dl;
    wire         cc1, cc2, gate, dis_on, sink1, sink20, drv_en, lowp, att, safe0, done;
    wire  [15:0] vbus, vref, ilim, ov_lvl, uv_lvl;
    int          err_count = 0, n_checks = 0, cyc = 0, k, i, seed = 32'hF421;
    always #12.5 ref_clk_i = ~ref_clk_i;
    pdss_sink_model u_sink (.ref_clk_i(ref_clk_i), .plug_i(plug), .flip_i(flip), .both_i(both),
        .gate_i(gate), .dis_on_i(dis_on), .supply_mv_i(supply), .cc1_below_thr_o(cc1),
        .cc2_below_thr_o(cc2), .vbus_mv_o(vbus));
    pdss_seq #(.RESTART_CYCLES(RST_C), .UNATT_CYCLES(UNATT_C), .RAMP_STEPS(8),
        .OVP_HIGH_SEL(1'b0))
    uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .supply_mv_i(supply), .vbus_mv_i(vbus),
        .supply_open_i(open_p), .vout_stable_i(stable), .cc1_below_thr_i(cc1),
        .cc2_below_thr_i(cc2), .new_req_i(req), .new_vout_mv_i(vnew), .hard_reset_i(hr),
        .fault_i(fault), .load_switch_gate_drive_o(gate), .output_discharge_pin_o(dis_on),
        .discharge_sink_1ma_o(sink1), .supply_sink_20ma_o(sink20),
        .optocoupler_drive_en_o(drv_en), .low_power_o(lowp), .attached_o(att),
        .vref_mv_o(vref), .ilim_ma_o(ilim), .ovp_level_mv_o(ov_lvl), .uvp_level_mv_o(uv_lvl),
        .below_safe0_o(safe0), .hr_done_o(done));
    function automatic logic [15:0] pct(input logic [15:0] a, input logic [7:0] p);
        return 16'(32'(a) * 32'(p) / 32'(pdss_pkg::PCT_DIV));
    endfunction : pct
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : tick
    task send(input logic [15:0] a);
        @(posedge ref_clk_i);
        req <= 1'b1;
        vnew <= a;
        @(posedge ref_clk_i);
        req <= 1'b0;
    endtask : send
    task trip(input int kind);
        supply <= 16'h1388;
        for (k = 0; k < 2000 && gate !== 1'b1; k++) tick(1);
        fault <= (kind == 0);
        open_p <= (kind == 2);
        if (kind == 1) supply <= 16'h07D0;
        tick(10);
        check(16'(gate), 16'h0000);
        check(16'(sink1), 16'h0001);
        fault <= 1'b0;
        open_p <= 1'b0;
        supply <= 16'h1388;
        for (k = 0; k < RST_C + 2000 && gate !== 1'b1; k++) tick(1);
        check(16'(k + 10 >= RST_C), 16'h0001);
        check(16'(gate), 16'h0001);
    endtask : trip
    task print_verdict;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 32'h186A0) begin
            err_count++;
            print_verdict();
        end
    end
    initial begin
        tick(3);
        rst_n_i <= 1'b1;
        check(vref, 16'h1388);
        check(ilim, 16'h0BB8);
        check(16'(drv_en), 16'h0000);
        check(16'(CABLE_COMP_MVA <= 200), 16'h0001);
        tick(10);
        check(16'(gate), 16'h0000);
        supply <= 16'h1518;
        stable <= 1'b1;
        tick(10);
        check(16'(sink20), 16'h0001);
        supply <= 16'h1388;
        for (k = 0; k < 500 && dis_on !== 1'b1; k++) tick(1);
        check(16'(gate), 16'h0000);
        check(16'(sink1), 16'h0000);
        for (k = 0; k < 500 && gate !== 1'b1; k++) tick(1);
        check(16'(k), 16'(UNATT_C));
        check(16'(lowp), 16'h0001);
        check(16'(dis_on), 16'h0000);
        check(16'(drv_en), 16'h0001);
        send(16'h2328);
        tick(105);
        check(vref, 16'h1388);
        check(16'(dis_on), 16'h0000);
        check(16'(sink20), 16'h0000);
        both <= 1'b1;
        plug <= 1'b1;
        tick(20);
        check(16'(att), 16'h0000);
        both <= 1'b0;
        flip <= 1'($random(seed));
        for (k = 0; k < 50 && att !== 1'b1; k++) tick(1);
        check(16'(lowp), 16'h0000);
        check(16'(safe0), 16'h0000);
        cur = 16'h1388;
        for (i = 0; i < 4; i++) begin
            v = cur + 16'h0001 + ((i == 0) ? 16'h0000 : 16'($unsigned($random(seed)) % 2000));
            send(v);
            tick(4);
            check(vref, v);
            supply <= v;
            tick(4);
            check(ov_lvl, pct(v, pdss_pkg::OVP_PCT_LO));
            check(uv_lvl, pct(v, pdss_pkg::UVP_PCT));
            cur = v;
        end
        send(16'h1388);
        last = cur;
        d0 = 16'h0000;
        for (k = 0; k < 8 * pdss_pkg::RAMP_STEP_CYC + 50 && vref !== 16'h1388; k++) begin
            tick(1);
            supply <= vref;
            if (k == 4) check(16'(vref > 16'h1388), 16'h0001);
            if (vref > last) check(vref, last);
            if (vref < last && d0 == 16'h0000) d0 = last - vref;
            if (vref < last) dl = last - vref;
            if (vref < last) last = vref;
        end
        check(vref, 16'h1388);
        check(16'(d0 >= dl), 16'h0001);
        send(16'h2328);
        tick(4);
        supply <= 16'h2328;
        plug <= 1'b0;
        for (k = 0; k < pdss_pkg::DETACH_CYC && vref !== 16'h1388; k++) begin
            tick(1);
            supply <= vref;
        end
        check(vref, 16'h1388);
        plug <= 1'b1;
        supply <= 16'h1194;
        for (k = 0; k < 50 && att !== 1'b1; k++) tick(1);
        tick(5);
        hr <= 1'b1;
        tick(1);
        hr <= 1'b0;
        plug <= 1'b0;
        tick(3);
        check(16'(gate), 16'h0000);
        check(16'(dis_on), 16'h0001);
        for (k = 0; k < pdss_pkg::PERIOD_CYC + 100 && dis_on !== 1'b0; k++) tick(1);
        dn = 1'b0;
        for (k = 0; k < 2000 && dis_on !== 1'b1; k++) begin
            tick(1);
            dn = dn | (done === 1'b1);
        end
        tick(1);
        dn = dn | (done === 1'b1);
        check(16'(k), 16'(pdss_pkg::GAP_CYC));
        check(16'(dn), 16'h0001);
        check(16'(lowp), 16'h0001);
        check(16'(safe0), 16'h0001);
        for (i = 0; i < 3; i++) trip(i);
        print_verdict();
    end
endmodule : test_pdss_seq
`default_nettype wire
